// ---- rtl/nibble_alu_pkg.sv ----
// Purpose: shared constants and types of the nibble alu
// Assumes: 11-bit data memory address = bank(4) row(3) column(4)
// Notes: register offsets are byte addresses on the avalon slave
package nibble_alu_pkg;
	localparam int NIB_W = 4;
	localparam int ADDR_W = 11;
	localparam int ROWCOL_W = 7;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [4:0] OFS_PSW = 5'h00;
	localparam logic [4:0] OFS_RP = 5'h04;
	localparam logic [4:0] OFS_IX = 5'h08;
	localparam logic [4:0] OFS_MP = 5'h0C;
	localparam logic [4:0] OFS_BANK = 5'h10;
	localparam logic [4:0] OFS_STAT = 5'h14;
	// ****************************************
	// program status word fields
	// ****************************************
	localparam int PSW_W = 6;
	localparam int PSW_IXE = 0;
	localparam int PSW_Z = 1;
	localparam int PSW_CY = 2;
	localparam int PSW_CMP = 3;
	localparam int PSW_BCD = 4;
	localparam int PSW_MPE = 5;
	localparam logic [5:0] PSW_RST = 6'h00;
	localparam logic [3:0] RP_RST = 4'h0;
	localparam logic [10:0] IX_RST = 11'h000;
	localparam logic [6:0] MP_RST = 7'h00;
	localparam logic [3:0] BANK_RST = 4'h0;
	localparam logic [4:0] DEC_LIMIT = 5'h09;
	localparam logic [4:0] DEC_FIX = 5'h06;
	// ****************************************
	// operations and sequencer states
	// ****************************************
	typedef enum logic [4:0] {
		OP_ADD = 5'h00, OP_ADDC = 5'h01, OP_SUB = 5'h02, OP_SUBC = 5'h03,
		OP_AND = 5'h04, OP_OR = 5'h05, OP_XOR = 5'h06,
		OP_SKT = 5'h07, OP_SKF = 5'h08, OP_SKE = 5'h09, OP_SKIP_IF_NOT_EQUAL = 5'h0A,
		OP_SKIP_IF_GREATER_EQUAL = 5'h0B, OP_SKIP_IF_LESS_THAN = 5'h0C,
		OP_LD = 5'h0D, OP_ST = 5'h0E, OP_MOVI = 5'h0F,
		OP_MOV_TO_IND = 5'h10, OP_MOV_FROM_IND = 5'h11, OP_ROTATE_RIGHT_THROUGH_CARRY = 5'h12
	} alu_op_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'h0, S_RDA = 3'h1, S_GETA = 3'h2, S_RDB = 3'h3,
		S_GETB = 3'h4, S_EXEC = 3'h5, S_DONE = 3'h6
	} seq_state_t;
	function automatic logic isArith(input alu_op_t op);
		return op inside {OP_ADD, OP_ADDC, OP_SUB, OP_SUBC};
	endfunction
	function automatic logic isLogic(input alu_op_t op);
		return op inside {OP_AND, OP_OR, OP_XOR};
	endfunction
	function automatic logic isSkip(input alu_op_t op);
		return op inside {OP_SKT, OP_SKF, OP_SKE, OP_SKIP_IF_NOT_EQUAL, OP_SKIP_IF_GREATER_EQUAL, OP_SKIP_IF_LESS_THAN};
	endfunction
endpackage

// ---- rtl/nibble_adder.sv ----
// Purpose: binary or decimal nibble add and subtract
// Assumes: decimal operands are digits 0 to 9
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module nibble_adder
	import nibble_alu_pkg::*;
(
	// operands
	input wire logic [3:0] a,
	input wire logic [3:0] b,
	input wire logic carryIn,
	// mode
	input wire logic subtract,
	input wire logic decimal,
	// result
	output logic [3:0] sum,
	output logic carryOut
);
	logic [4:0] raw;
	logic [4:0] fixed;
	always_comb begin
		if (subtract) begin
			raw = {1'b0, a} - {1'b0, b} - {4'h0, carryIn};
		end else begin
			raw = {1'b0, a} + {1'b0, b} + {4'h0, carryIn};
		end
		fixed = raw;
		carryOut = raw[4];
		if (decimal && !subtract && raw > DEC_LIMIT) begin
			fixed = raw + DEC_FIX;
			carryOut = 1'b1;
		end else if (decimal && subtract && raw[4]) begin
			fixed = raw - DEC_FIX;
			carryOut = 1'b1;
		end
		sum = fixed[3:0];
	end
endmodule
`default_nettype wire

// ---- rtl/nibble_alu_with_flags.sv ----
// Purpose: 4-bit alu, flags and operand address control of the core
// Assumes: data memory answers a read one cycle after memRe is seen
// Notes: registers reached over avalon-mm with waitrequest
//
// Overview of operation
// - indirect moves: register row from pointer, column from instruction operand
// - indirect target: bank and row of direct operand, or mp when MPE set; column from register contents
// - register row and lowest bank bit come only from the register pointer; upper three bank bits are zero
// - immediate operands only combine with directly addressed memory
// - two hidden 4-bit temporaries hold operands during execution
// - decimal flag set: add and subtract results are decimal adjusted
// - address control makes every memory operand address with enabled modifiers
// - decimal flag picks arithmetic kind; compare flag suppresses add and subtract write back
// - compare flag clear: zero flag set on zero result, else cleared
// - compare flag set: zero flag held on zero result, else cleared
// - only add, subtract and rotate touch carry; only add and subtract touch zero; others keep flags
// - rotate right shifts register through carry, zero flag kept
// - index modifies all memory operands but rotation; row pointer only indirect
// - add and subtract set carry on carry or borrow, else clear
// - index and row pointer modification gated by status word flags
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module nibble_alu_with_flags
	import nibble_alu_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// instruction from decoder
	input wire logic instrValid,
	output logic instrReady,
	input wire logic [4:0] instrOp,
	input wire logic immForm,
	input wire logic [3:0] instrR,
	input wire logic [6:0] instrM,
	input wire logic [3:0] instrImm,
	output logic instrDone,
	output logic skipNext,
	// data memory
	output logic [10:0] memAddr,
	output logic memRe,
	output logic memWe,
	output logic [3:0] memWdata,
	input wire logic [3:0] memRdata
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		seq_state_t state;
		alu_op_t op;
		logic imm;
		logic [3:0] rCol;
		logic [3:0] immVal;
		logic [10:0] grAddr;
		logic [10:0] mEff;
		logic [10:0] indAddr;
		logic [3:0] tmpA;
		logic [3:0] tmpB;
		logic [10:0] addr;
		logic re;
		logic we;
		logic [3:0] wdata;
		logic done;
		logic skip;
		logic [5:0] psw;
		logic [3:0] rp;
		logic [10:0] ix;
		logic [6:0] mp;
		logic [3:0] bank;
		logic ack;
		logic [31:0] rdata;
	} alu_state_t;
	alu_state_t cur_ff;
	alu_state_t nxt_cur;
	logic [3:0] aluSum;
	logic aluCo;
	logic busAcc;
	logic pswWr;
	logic [15:0] wmask;
	logic [15:0] wval;
	logic aluSub;
	logic aluCin;
	// ****************************************
	// address helpers
	// ****************************************
	function automatic logic [10:0] modIndex(input logic [10:0] a, input logic [5:0] psw, input logic [10:0] ix);
		return psw[PSW_IXE] ? (a | ix) : a;
	endfunction
	function automatic logic [10:0] regAddr(input logic [3:0] rp, input logic [3:0] col);
		return {3'h0, rp, col};
	endfunction
	function automatic logic [31:0] regRead(input logic [4:0] a, input alu_state_t s);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			OFS_PSW: v[5:0] = s.psw;
			OFS_RP: v[3:0] = s.rp;
			OFS_IX: v[10:0] = s.ix;
			OFS_MP: v[6:0] = s.mp;
			OFS_BANK: v[3:0] = s.bank;
			OFS_STAT: v[1:0] = {s.skip, s.state != S_IDLE};
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction
	// ****************************************
	// arithmetic stage
	// ****************************************
	assign aluSub = cur_ff.op inside {OP_SUB, OP_SUBC};
	assign aluCin = (cur_ff.op inside {OP_ADDC, OP_SUBC}) & cur_ff.psw[PSW_CY];
	nibble_adder adder (
		.a(cur_ff.tmpA),
		.b(cur_ff.tmpB),
		.carryIn(aluCin),
		.subtract(aluSub),
		.decimal(cur_ff.psw[PSW_BCD]),
		.sum(aluSum),
		.carryOut(aluCo)
	);
	assign busAcc = (avs_read | avs_write) & cur_ff.ack;
	assign pswWr = busAcc & avs_write & (avs_address == OFS_PSW) & avs_byteenable[0];
	assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.done = 1'b0;
		nxt_cur.re = 1'b0;
		nxt_cur.we = 1'b0;
		wval = avs_writedata[15:0];
		// bus slave: one wait cycle, then answer
		nxt_cur.ack = (avs_read | avs_write) & !cur_ff.ack;
		if ((avs_read | avs_write) && !cur_ff.ack) begin
			nxt_cur.rdata = regRead(avs_address, cur_ff);
		end
		if (busAcc && avs_write) begin
			case (avs_address)
				OFS_PSW: nxt_cur.psw = (cur_ff.psw & ~wmask[5:0]) | (wval[5:0] & wmask[5:0]);
				OFS_RP: nxt_cur.rp = (cur_ff.rp & ~wmask[3:0]) | (wval[3:0] & wmask[3:0]);
				OFS_IX: nxt_cur.ix = (cur_ff.ix & ~wmask[10:0]) | (wval[10:0] & wmask[10:0]);
				OFS_MP: nxt_cur.mp = (cur_ff.mp & ~wmask[6:0]) | (wval[6:0] & wmask[6:0]);
				OFS_BANK: nxt_cur.bank = (cur_ff.bank & ~wmask[3:0]) | (wval[3:0] & wmask[3:0]);
				default: nxt_cur.bank = nxt_cur.bank;
			endcase
		end
		case (cur_ff.state)
			S_IDLE: begin
				if (instrValid) begin
					nxt_cur.op = alu_op_t'(instrOp);
					// immediate form only for direct memory operands
					nxt_cur.imm = immForm & (isArith(alu_op_t'(instrOp)) | isLogic(alu_op_t'(instrOp)));
					nxt_cur.rCol = instrR;
					nxt_cur.immVal = instrImm;
					nxt_cur.grAddr = regAddr(cur_ff.rp, instrR);
					nxt_cur.mEff = modIndex({cur_ff.bank, instrM}, cur_ff.psw, cur_ff.ix);
					nxt_cur.skip = 1'b0;
					nxt_cur.state = S_RDA;
				end
			end
			S_RDA: begin
				nxt_cur.re = cur_ff.op != OP_MOVI;
				if (isSkip(cur_ff.op) || cur_ff.imm) begin
					nxt_cur.addr = cur_ff.mEff;
				end else begin
					nxt_cur.addr = cur_ff.grAddr;
				end
				nxt_cur.state = S_GETA;
			end
			S_GETA: begin
				nxt_cur.state = S_RDB;
			end
			S_RDB: begin
				nxt_cur.tmpA = memRdata;
				// indirect column from register contents, bank and row direct or pointer
				if (cur_ff.psw[PSW_MPE]) begin
					nxt_cur.indAddr = modIndex({cur_ff.mp, memRdata}, cur_ff.psw, cur_ff.ix);
				end else begin
					nxt_cur.indAddr = modIndex({cur_ff.mEff[10:4], memRdata}, cur_ff.psw, cur_ff.ix);
				end
				nxt_cur.re = !(cur_ff.imm || isSkip(cur_ff.op) || cur_ff.op inside {OP_MOVI, OP_ST, OP_ROTATE_RIGHT_THROUGH_CARRY});
				if (cur_ff.op == OP_MOV_FROM_IND) begin
					nxt_cur.addr = nxt_cur.indAddr;
				end else begin
					nxt_cur.addr = cur_ff.mEff;
				end
				nxt_cur.state = S_GETB;
			end
			S_GETB: begin
				nxt_cur.state = S_EXEC;
			end
			S_EXEC: begin
				nxt_cur.tmpB = (cur_ff.imm || isSkip(cur_ff.op) || cur_ff.op == OP_MOVI) ? cur_ff.immVal : memRdata;
				nxt_cur.state = S_DONE;
			end
			S_DONE: begin
				nxt_cur.done = 1'b1;
				nxt_cur.state = S_IDLE;
				nxt_cur.addr = cur_ff.imm ? cur_ff.mEff : cur_ff.grAddr;
				nxt_cur.we = 1'b1;
				nxt_cur.wdata = cur_ff.tmpB;
				if (isArith(cur_ff.op)) begin
					nxt_cur.wdata = aluSum;
					nxt_cur.we = !cur_ff.psw[PSW_CMP];
					nxt_cur.psw[PSW_CY] = aluCo;
					if (aluSum != 4'h0) begin
						nxt_cur.psw[PSW_Z] = 1'b0;
					end else if (!cur_ff.psw[PSW_CMP]) begin
						nxt_cur.psw[PSW_Z] = 1'b1;
					end
				end else if (isLogic(cur_ff.op)) begin
					// flags untouched by logic, moves and tests
					case (cur_ff.op)
						OP_AND: nxt_cur.wdata = cur_ff.tmpA & cur_ff.tmpB;
						OP_OR: nxt_cur.wdata = cur_ff.tmpA | cur_ff.tmpB;
						default: nxt_cur.wdata = cur_ff.tmpA ^ cur_ff.tmpB;
					endcase
				end else if (isSkip(cur_ff.op)) begin
					nxt_cur.we = 1'b0;
					case (cur_ff.op)
						OP_SKT: nxt_cur.skip = (cur_ff.tmpA & cur_ff.tmpB) == cur_ff.tmpB;
						OP_SKF: nxt_cur.skip = (cur_ff.tmpA & cur_ff.tmpB) == 4'h0;
						OP_SKE: nxt_cur.skip = cur_ff.tmpA == cur_ff.tmpB;
						OP_SKIP_IF_NOT_EQUAL: nxt_cur.skip = cur_ff.tmpA != cur_ff.tmpB;
						OP_SKIP_IF_GREATER_EQUAL: nxt_cur.skip = cur_ff.tmpA >= cur_ff.tmpB;
						default: nxt_cur.skip = cur_ff.tmpA < cur_ff.tmpB;
					endcase
				end else begin
					case (cur_ff.op)
						OP_ST, OP_MOVI, OP_MOV_FROM_IND: begin
							nxt_cur.addr = cur_ff.mEff;
							nxt_cur.wdata = (cur_ff.op == OP_ST) ? cur_ff.tmpA : cur_ff.tmpB;
						end
						OP_MOV_TO_IND: nxt_cur.addr = cur_ff.indAddr;
						OP_ROTATE_RIGHT_THROUGH_CARRY: begin
							nxt_cur.wdata = {cur_ff.psw[PSW_CY], cur_ff.tmpA[3:1]};
							nxt_cur.psw[PSW_CY] = cur_ff.tmpA[0];
						end
						default: nxt_cur.wdata = cur_ff.tmpB;
					endcase
				end
			end
			default: nxt_cur.state = S_IDLE;
		endcase
		if (rst) begin
			nxt_cur = '0;
			nxt_cur.state = S_IDLE;
			nxt_cur.psw = PSW_RST;
			nxt_cur.rp = RP_RST;
			nxt_cur.ix = IX_RST;
			nxt_cur.mp = MP_RST;
			nxt_cur.bank = BANK_RST;
		end
	end
	always_ff @(posedge clk_sys) begin
		cur_ff <= nxt_cur;
	end
	// ****************************************
	// outputs
	// ****************************************
	assign instrReady = cur_ff.state == S_IDLE;
	assign instrDone = cur_ff.done;
	assign skipNext = cur_ff.skip;
	assign memAddr = cur_ff.addr;
	assign memRe = cur_ff.re;
	assign memWe = cur_ff.we;
	assign memWdata = cur_ff.wdata;
	assign avs_readdata = cur_ff.rdata;
	assign avs_waitrequest = (avs_read | avs_write) & !cur_ff.ack;
	// ****************************************
	// checks
	// ****************************************
	gr_row_a: assert property (@(posedge clk_sys) disable iff (rst)
		(cur_ff.state == S_IDLE && instrValid) |=> cur_ff.grAddr[7:4] == $past(cur_ff.rp))
		else $error("register row not from pointer");
	ind_col_a: assert property (@(posedge clk_sys) disable iff (rst)
		(cur_ff.state == S_RDB && !cur_ff.psw[PSW_IXE] && !cur_ff.psw[PSW_MPE])
		|=> cur_ff.indAddr == {$past(cur_ff.mEff[10:4]), $past(memRdata)})
		else $error("indirect address wrong");
	cmp_nostore_a: assert property (@(posedge clk_sys) disable iff (rst)
		(cur_ff.state == S_DONE && isArith(cur_ff.op) && cur_ff.psw[PSW_CMP]) |=> !memWe && instrDone)
		else $error("result stored under compare");
	zero_set_a: assert property (@(posedge clk_sys) disable iff (rst)
		(cur_ff.state == S_DONE && isArith(cur_ff.op) && !cur_ff.psw[PSW_CMP] && !pswWr)
		|=> cur_ff.psw[PSW_Z] == ($past(aluSum) == 4'h0) && memWdata == $past(aluSum))
		else $error("zero flag wrong");
	zero_chain_a: assert property (@(posedge clk_sys) disable iff (rst)
		(cur_ff.state == S_DONE && isArith(cur_ff.op) && cur_ff.psw[PSW_CMP] && aluSum == 4'h0 && !pswWr)
		|=> $stable(cur_ff.psw[PSW_Z]))
		else $error("zero flag not held");
	carry_set_a: assert property (@(posedge clk_sys) disable iff (rst)
		(cur_ff.state == S_DONE && isArith(cur_ff.op) && !pswWr) |=> cur_ff.psw[PSW_CY] == $past(aluCo))
		else $error("carry flag wrong");
	flags_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
		(cur_ff.state == S_DONE && !isArith(cur_ff.op) && cur_ff.op != OP_ROTATE_RIGHT_THROUGH_CARRY && !pswWr)
		|=> $stable(cur_ff.psw))
		else $error("flags changed");
	rotate_a: assert property (@(posedge clk_sys) disable iff (rst)
		(cur_ff.state == S_DONE && cur_ff.op == OP_ROTATE_RIGHT_THROUGH_CARRY && !pswWr)
		|=> cur_ff.psw[PSW_CY] == $past(cur_ff.tmpA[0]) && memWdata == {$past(cur_ff.psw[PSW_CY]), $past(cur_ff.tmpA[3:1])}
		&& $stable(cur_ff.psw[PSW_Z]))
		else $error("rotate wrong");
	skip_nowrite_a: assert property (@(posedge clk_sys) disable iff (rst)
		(cur_ff.state == S_DONE && isSkip(cur_ff.op)) |=> !memWe && instrDone)
		else $error("skip wrote memory");
	bcd_digit_a: assert property (@(posedge clk_sys) disable iff (rst)
		(cur_ff.state == S_DONE && isArith(cur_ff.op) && cur_ff.psw[PSW_BCD]
		&& cur_ff.tmpA <= 4'h9 && cur_ff.tmpB <= 4'h9) |=> memWdata <= 4'h9)
		else $error("decimal result not a digit");
	index_mod_a: assert property (@(posedge clk_sys) disable iff (rst)
		(cur_ff.state == S_IDLE && instrValid && !cur_ff.psw[PSW_IXE]) |=> cur_ff.mEff == {$past(cur_ff.bank), $past(instrM)})
		else $error("index applied while disabled");
endmodule
`default_nettype wire

// ---- test/nibble_mem_model.sv ----
// Purpose: nibble-wide data memory at the far side of the alu
// Assumes: read data is due in the cycle after the read strobe
// Notes: outside that cycle the read bus shows changing junk
`timescale 1ns/1ps
`default_nettype none
module nibble_mem_model (
	// clock
	input wire logic clk_sys,
	// memory side
	input wire logic [10:0] memAddr,
	input wire logic memRe,
	input wire logic memWe,
	input wire logic [3:0] memWdata,
	output logic [3:0] memRdata
);
	logic [3:0] cells [0:2047];
	initial begin
		memRdata = 4'h5;
		for (int i = 0; i < 2048; i++)
			cells[i] = 4'h0;
	end
	always @(posedge clk_sys) begin
		if (memWe)
			cells[memAddr] <= memWdata;
		// data held one cycle, inverted afterwards
		if (memRe)
			memRdata <= cells[memAddr];
		else
			memRdata <= ~memRdata;
	end
endmodule
`default_nettype wire

// ---- test/nibble_alu_with_flags_bench.sv ----
// Purpose: self-checking bench of the nibble alu
// Assumes: memory model answers one cycle after the read strobe
// Notes: registers reached through avalon-mm tasks
`timescale 1ns/1ps
`default_nettype none
module nibble_alu_with_flags_bench;
	import nibble_alu_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic instrValid = 1'b0;
	logic instrReady;
	logic [4:0] instrOp = 5'h00;
	logic immForm = 1'b0;
	logic [3:0] instrR = 4'h0;
	logic [6:0] instrM = 7'h00;
	logic [3:0] instrImm = 4'h0;
	logic instrDone;
	logic skipNext;
	logic [10:0] memAddr;
	logic memRe;
	logic memWe;
	logic [3:0] memWdata;
	logic [3:0] memRdata;
	int err_count = 0;
	int n_compared = 0;
	nibble_alu_with_flags dut_u (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .instrValid(instrValid),
		.instrReady(instrReady), .instrOp(instrOp), .immForm(immForm), .instrR(instrR), .instrM(instrM),
		.instrImm(instrImm), .instrDone(instrDone), .skipNext(skipNext), .memAddr(memAddr), .memRe(memRe),
		.memWe(memWe), .memWdata(memWdata), .memRdata(memRdata));
	nibble_mem_model mem_u (.clk_sys(clk_sys), .memAddr(memAddr), .memRe(memRe), .memWe(memWe),
		.memWdata(memWdata), .memRdata(memRdata));
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic print_verdict;
		if (err_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		for (int k = 0; k < 20; k++) begin
			@(negedge clk_sys);
			if (avs_waitrequest === 1'b0)
				break;
		end
		chk(avs_waitrequest, 0, "bus answer");
		q = avs_readdata;
		@(posedge clk_sys);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wrReg(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdChk(input logic [4:0] a, input logic [31:0] exp, input string what);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp, what);
	endtask
	task automatic exec(input alu_op_t op, input logic imm, input logic [3:0] r, input logic [6:0] m,
		input logic [3:0] n);
		int k;
		@(posedge clk_sys);
		instrOp <= op;
		immForm <= imm;
		instrR <= r;
		instrM <= m;
		instrImm <= n;
		instrValid <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(negedge clk_sys);
			if (instrReady === 1'b1)
				break;
		end
		@(posedge clk_sys);
		instrValid <= 1'b0;
		for (k = 1; k < 20; k++) begin
			@(negedge clk_sys);
			if (instrDone === 1'b1)
				break;
		end
		chk(k, 7, "done latency");
		@(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic tReset;
		logic [4:0] ofs [6] = '{OFS_PSW, OFS_RP, OFS_IX, OFS_MP, OFS_BANK, OFS_STAT};
		for (int i = 0; i < 6; i++)
			rdChk(ofs[i], 32'h0, "reset value");
		wrReg(5'h18, 32'hFFFFFFFF);
		wrReg(OFS_STAT, 32'hFFFFFFFF);
		rdChk(5'h18, 32'h0, "unmapped read");
		rdChk(OFS_STAT, 32'h0, "status read only");
		wrReg(OFS_IX, 32'hFFFFFFFF);
		rdChk(OFS_IX, 32'h7FF, "index width");
	endtask
	task automatic tArith;
		wrReg(OFS_RP, 32'h2);
		wrReg(OFS_BANK, 32'h1);
		wrReg(OFS_IX, 32'h0);
		wrReg(OFS_PSW, 32'h0);
		mem_u.cells[11'h023] = 4'h9;
		mem_u.cells[11'h095] = 4'h8;
		exec(OP_ADD, 1'b0, 4'h3, 7'h15, 4'h0);
		chk(mem_u.cells[11'h023], 4'h1, "add r,m result");
		rdChk(OFS_PSW, 32'h04, "add carry");
		mem_u.cells[11'h095] = 4'hE;
		exec(OP_ADDC, 1'b1, 4'h3, 7'h15, 4'h1);
		chk(mem_u.cells[11'h095], 4'h0, "addc imm result");
		chk(mem_u.cells[11'h023], 4'h1, "register untouched");
		rdChk(OFS_PSW, 32'h06, "zero and carry");
		wrReg(OFS_PSW, 32'h10);
		mem_u.cells[11'h095] = 4'h7;
		exec(OP_ADD, 1'b1, 4'h0, 7'h15, 4'h5);
		chk(mem_u.cells[11'h095], 4'h2, "decimal add");
		rdChk(OFS_PSW, 32'h14, "decimal carry");
		mem_u.cells[11'h095] = 4'h3;
		exec(OP_SUB, 1'b1, 4'h0, 7'h15, 4'h5);
		chk(mem_u.cells[11'h095], 4'h8, "decimal sub");
		rdChk(OFS_PSW, 32'h14, "decimal borrow");
	endtask
	task automatic tCompare;
		wrReg(OFS_PSW, 32'h0A);
		mem_u.cells[11'h095] = 4'h5;
		exec(OP_SUB, 1'b1, 4'h0, 7'h15, 4'h5);
		rdChk(OFS_PSW, 32'h0A, "zero held");
		exec(OP_SUB, 1'b1, 4'h0, 7'h15, 4'h3);
		rdChk(OFS_PSW, 32'h08, "zero cleared");
		exec(OP_SUB, 1'b1, 4'h0, 7'h15, 4'h5);
		rdChk(OFS_PSW, 32'h08, "clear zero held");
		chk(mem_u.cells[11'h095], 4'h5, "no store");
	endtask
	task automatic tLogic;
		alu_op_t ops [3] = '{OP_AND, OP_OR, OP_XOR};
		logic [3:0] res [3] = '{4'h8, 4'hA, 4'h0};
		wrReg(OFS_PSW, 32'h14);
		mem_u.cells[11'h023] = 4'hC;
		mem_u.cells[11'h095] = 4'hA;
		for (int i = 0; i < 3; i++) begin
			exec(ops[i], 1'b0, 4'h3, 7'h15, 4'h0);
			chk(mem_u.cells[11'h023], res[i], "logic result");
		end
		rdChk(OFS_PSW, 32'h14, "logic flags kept");
	endtask
	task automatic tSkip;
		alu_op_t ops [7] = '{OP_SKT, OP_SKT, OP_SKF, OP_SKE, OP_SKIP_IF_NOT_EQUAL, OP_SKIP_IF_GREATER_EQUAL, OP_SKIP_IF_LESS_THAN};
		logic [3:0] n [7] = '{4'h4, 4'h3, 4'h8, 4'h6, 4'h6, 4'h7, 4'h7};
		logic s [7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
		wrReg(OFS_PSW, 32'h0C);
		mem_u.cells[11'h095] = 4'h6;
		for (int i = 0; i < 7; i++) begin
			exec(ops[i], 1'b1, 4'h0, 7'h15, n[i]);
			chk(skipNext, s[i], "skip result");
		end
		chk(mem_u.cells[11'h095], 4'h6, "skip no write");
		rdChk(OFS_STAT, 32'h2, "skip status");
		rdChk(OFS_PSW, 32'h0C, "skip flags kept");
	endtask
	task automatic tRotate;
		wrReg(OFS_IX, 32'h040);
		wrReg(OFS_PSW, 32'h03);
		mem_u.cells[11'h023] = 4'hB;
		exec(OP_ROTATE_RIGHT_THROUGH_CARRY, 1'b0, 4'h3, 7'h15, 4'h0);
		chk(mem_u.cells[11'h023], 4'h5, "rotate result");
		rdChk(OFS_PSW, 32'h07, "rotate carry");
	endtask
	task automatic tIndex;
		wrReg(OFS_PSW, 32'h01);
		mem_u.cells[11'h0D5] = 4'hD;
		mem_u.cells[11'h095] = 4'h1;
		exec(OP_LD, 1'b0, 4'h4, 7'h15, 4'h0);
		chk(mem_u.cells[11'h024], 4'hD, "indexed load");
		wrReg(OFS_PSW, 32'h00);
		exec(OP_LD, 1'b0, 4'h4, 7'h15, 4'h0);
		chk(mem_u.cells[11'h024], 4'h1, "index disabled");
	endtask
	task automatic tIndirect;
		mem_u.cells[11'h025] = 4'h7;
		mem_u.cells[11'h095] = 4'hC;
		exec(OP_MOV_TO_IND, 1'b0, 4'h5, 7'h15, 4'h0);
		chk(mem_u.cells[11'h097], 4'hC, "indirect store");
		wrReg(OFS_MP, 32'h2A);
		wrReg(OFS_IX, 32'h100);
		wrReg(OFS_PSW, 32'h21);
		mem_u.cells[11'h3A7] = 4'h6;
		exec(OP_MOV_FROM_IND, 1'b0, 4'h5, 7'h15, 4'h0);
		chk(mem_u.cells[11'h195], 4'h6, "pointer load");
		chk(mem_u.cells[11'h025], 4'h7, "register kept");
	endtask
	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		tReset();
		tArith();
		tCompare();
		tLogic();
		tSkip();
		tRotate();
		tIndex();
		tIndirect();
		print_verdict();
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		err_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
